// ==== common/gppr_pkg.sv ====
// gppr_pkg: register map, control field layout, pin mode codes and pin
// positions for the gpio port with pin routing.
// assumes a 32-bit apb slave, one register per aligned word.
package gppr_pkg;

  // ==========================================================
  // widths
  localparam int unsigned GPPR_DATA_W = 32;
  localparam int unsigned GPPR_REG_W = 16;
  localparam int unsigned GPPR_PINS = 32;
  localparam int unsigned GPPR_LANES = 4;
  localparam int unsigned GPPR_XD_LO = 8;
  localparam int unsigned GPPR_XD_HI = 15;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] GPPR_IDX_CONTROL = 16'hC006;
  localparam logic [15:0] GPPR_IDX_B0_OUT = 16'hC01E;
  localparam logic [15:0] GPPR_IDX_B0_IN = 16'hC020;
  localparam logic [15:0] GPPR_IDX_B0_DIR = 16'hC022;
  localparam logic [15:0] GPPR_IDX_B1_OUT = 16'hC024;
  localparam logic [15:0] GPPR_IDX_B1_IN = 16'hC026;
  localparam logic [15:0] GPPR_IDX_B1_DIR = 16'hC028;

  localparam logic [31:0] GPPR_ADDR_CONTROL = {14'h0000, GPPR_IDX_CONTROL, 2'h0};
  localparam logic [31:0] GPPR_ADDR_B0_OUT = {14'h0000, GPPR_IDX_B0_OUT, 2'h0};
  localparam logic [31:0] GPPR_ADDR_B0_IN = {14'h0000, GPPR_IDX_B0_IN, 2'h0};
  localparam logic [31:0] GPPR_ADDR_B0_DIR = {14'h0000, GPPR_IDX_B0_DIR, 2'h0};
  localparam logic [31:0] GPPR_ADDR_B1_OUT = {14'h0000, GPPR_IDX_B1_OUT, 2'h0};
  localparam logic [31:0] GPPR_ADDR_B1_IN = {14'h0000, GPPR_IDX_B1_IN, 2'h0};
  localparam logic [31:0] GPPR_ADDR_B1_DIR = {14'h0000, GPPR_IDX_B1_DIR, 2'h0};

  // ==========================================================
  // reset values and control masks
  localparam logic [15:0] GPPR_RST_REG = 16'h0000;
  localparam logic [15:0] GPPR_CTL_WRITABLE = 16'hCFFF;
  localparam logic [15:0] GPPR_CTL_LOCKED = 16'hFF00;

  // ==========================================================
  // control register fields
  localparam int unsigned GPPR_CTL_WP = 15;
  localparam int unsigned GPPR_CTL_UD = 14;
  localparam int unsigned GPPR_CTL_ALT_SS = 11;
  localparam int unsigned GPPR_CTL_MODE_HI = 10;
  localparam int unsigned GPPR_CTL_MODE_LO = 8;
  localparam int unsigned GPPR_CTL_FS_PIN = 7;
  localparam int unsigned GPPR_CTL_FS_XD = 6;
  localparam int unsigned GPPR_CTL_SPI_PIN = 5;
  localparam int unsigned GPPR_CTL_SPI_XD = 4;
  localparam int unsigned GPPR_CTL_IRQB_POL = 3;
  localparam int unsigned GPPR_CTL_IRQB_EN = 2;
  localparam int unsigned GPPR_CTL_IRQA_POL = 1;
  localparam int unsigned GPPR_CTL_IRQA_EN = 0;

  // ==========================================================
  // pin mode codes
  typedef enum logic [2:0] {
    GPPR_MODE_GPIO = 3'h0,
    GPPR_MODE_RSV1 = 3'h1,
    GPPR_MODE_RSV2 = 3'h2,
    GPPR_MODE_RSV3 = 3'h3,
    GPPR_MODE_DRIVE = 3'h4,
    GPPR_MODE_HOST = 3'h5,
    GPPR_MODE_SCAN = 3'h6,
    GPPR_MODE_RSV7 = 3'h7
  } gppr_mode_t;

  // ==========================================================
  // pin positions
  localparam logic [31:0] GPPR_MODE_PIN_MASK = 32'h01F8FFFF;
  localparam int unsigned GPPR_PIN_IRQA = 24;
  localparam int unsigned GPPR_PIN_IRQB = 25;
  localparam int unsigned GPPR_PIN_UD = 30;
  localparam int unsigned GPPR_PIN_ALT_SS = 15;
  localparam int unsigned GPPR_PIN_FS_LO = 16;
  localparam int unsigned GPPR_PIN_FS_HI = 26;
  localparam int unsigned GPPR_FS_HI_LANE = 3;
  localparam int unsigned GPPR_PIN_SPI_LO = 8;
  localparam int unsigned GPPR_SPI_SS_LANE = 1;
  localparam int unsigned GPPR_XD_FS_LO = 12;
  localparam int unsigned GPPR_XD_SPI_LO = 8;

endpackage : gppr_pkg

// ==== rtl/gppr_pin_sync.sv ====
// gppr_pin_sync: three-stage synchroniser with agreement filter per bit.
// assumes asynchronous pin levels; output moves only when stages two and
// three agree, so a one-sample glitch never reaches the block.
`timescale 1ns/10ps
module gppr_pin_sync #(
  parameter int unsigned WIDTH = 40
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_reg;

  // ==========================================================
  // capture chain
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // ==========================================================
  // agreement filter
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stable_reg <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          stable_reg[i] <= stage3_reg[i];
        end
      end
    end
  end

  assign syncOut = stable_reg;

endmodule : gppr_pin_sync

// ==== rtl/gppr_top.sv ====
// gppr_top: 32-pin general purpose port with pin routing, apb registers.
// assumes one sys_clk domain; pins and memory data lines are asynchronous
// and are synchronised here; peripheral cores sit on the same clock.
//
// How it works
// - mode field picks owner of pins 15:0 and 24:19: gpio, drive, host.
// - fast serial route bit puts port onto pins 26 and 18:16.
// - fast serial memory bus bit moves port to data lines 15:12, wins.
// - spi route bit puts spi port onto pins 11:8.
// - alternate select bit moves spi slave select input to pin 15.
// - spi memory bus bit puts spi on data lines 11:8, overriding both.
// - second pin interrupt edge: rising when polarity bit set, else falling.
// - second pin interrupt needs its enable and the cpu gpio enable.
// - first pin interrupt edge: rising when polarity bit set, else falling.
// - first pin interrupt needs its enable and the cpu gpio enable.
// - bank output registers drive pins 15:0 and 31:16 bit for bit.
// - output register reads return last written value, not pin levels.
// - input registers return pin levels of each bank.
// - direction bit one makes pin output, zero makes it input.
// - write protect freezes control bits 15:8 until reset.
// - alternate select only acts while spi sits on the pins.
// - first pin interrupt senses pin 24, second senses pin 25.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module gppr_top
  import gppr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [gppr_pkg::GPPR_DATA_W-1:0] pwdata,
  output logic [gppr_pkg::GPPR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gppr_pkg::GPPR_PINS-1:0] gpioIn,
  output logic [gppr_pkg::GPPR_PINS-1:0] gpioOut,
  output logic [gppr_pkg::GPPR_PINS-1:0] gpioOe,
  output logic [gppr_pkg::GPPR_PINS-1:0] pinLevel,
  input wire logic [gppr_pkg::GPPR_XD_HI:gppr_pkg::GPPR_XD_LO] xdIn,
  output logic [gppr_pkg::GPPR_XD_HI:gppr_pkg::GPPR_XD_LO] xdOut,
  output logic [gppr_pkg::GPPR_XD_HI:gppr_pkg::GPPR_XD_LO] xdOe,
  output logic [gppr_pkg::GPPR_XD_HI:gppr_pkg::GPPR_XD_LO] xdClaim,
  input wire logic [gppr_pkg::GPPR_LANES-1:0] fastSerialOut,
  input wire logic [gppr_pkg::GPPR_LANES-1:0] fastSerialOe,
  output logic [gppr_pkg::GPPR_LANES-1:0] fastSerialIn,
  input wire logic [gppr_pkg::GPPR_LANES-1:0] spiOut,
  input wire logic [gppr_pkg::GPPR_LANES-1:0] spiOe,
  output logic [gppr_pkg::GPPR_LANES-1:0] spiIn,
  input wire logic [gppr_pkg::GPPR_PINS-1:0] hostPortOut,
  input wire logic [gppr_pkg::GPPR_PINS-1:0] hostPortOe,
  input wire logic [gppr_pkg::GPPR_PINS-1:0] drivePortOut,
  input wire logic [gppr_pkg::GPPR_PINS-1:0] drivePortOe,
  output gppr_pkg::gppr_mode_t pinMode,
  input wire logic txEnStatus,
  input wire logic cpuGpioIntEn,
  output logic pinIrqA,
  output logic pinIrqB
);

  localparam int unsigned XD_W = GPPR_XD_HI - GPPR_XD_LO + 1;
  localparam int unsigned SYNC_W = GPPR_PINS + XD_W;

  // ==========================================================
  // declarations
  logic [GPPR_REG_W-1:0] control_reg;
  logic [GPPR_REG_W-1:0] control_next;
  logic [GPPR_REG_W-1:0] bank0Out_reg;
  logic [GPPR_REG_W-1:0] bank1Out_reg;
  logic [GPPR_REG_W-1:0] bank0Dir_reg;
  logic [GPPR_REG_W-1:0] bank1Dir_reg;
  logic [GPPR_DATA_W-1:0] prdata_reg;
  logic [GPPR_PINS-1:0] pinOut_reg;
  logic [GPPR_PINS-1:0] pinOut_next;
  logic [GPPR_PINS-1:0] pinOe_reg;
  logic [GPPR_PINS-1:0] pinOe_next;
  logic [XD_W-1:0] xdOut_reg;
  logic [XD_W-1:0] xdOut_next;
  logic [XD_W-1:0] xdOe_reg;
  logic [XD_W-1:0] xdOe_next;
  logic [XD_W-1:0] xdClaim_reg;
  logic [XD_W-1:0] xdClaim_next;
  logic [GPPR_LANES-1:0] fastSerialIn_reg;
  logic [GPPR_LANES-1:0] fastSerialIn_next;
  logic [GPPR_LANES-1:0] spiIn_reg;
  logic [GPPR_LANES-1:0] spiIn_next;
  logic [SYNC_W-1:0] syncLevel;
  logic [GPPR_PINS-1:0] pinSync;
  logic [XD_W-1:0] xdSync;
  logic irqAPrev_reg;
  logic irqBPrev_reg;
  logic pinIrqA_reg;
  logic pinIrqB_reg;
  logic wrStrobe;
  logic rdSetup;
  logic fsOnXd;
  logic fsOnPins;
  logic spiOnXd;
  logic spiOnPins;
  logic altSsActive;
  gppr_mode_t mode;

  // ==========================================================
  // helpers
  function automatic logic addrHit(input logic [31:0] addr);
    addrHit = (addr == GPPR_ADDR_CONTROL) || (addr == GPPR_ADDR_B0_OUT) ||
              (addr == GPPR_ADDR_B0_IN) || (addr == GPPR_ADDR_B0_DIR) ||
              (addr == GPPR_ADDR_B1_OUT) || (addr == GPPR_ADDR_B1_IN) ||
              (addr == GPPR_ADDR_B1_DIR);
  endfunction : addrHit

  // edge of the selected polarity on a synchronised level
  function automatic logic edgeSeen(input logic cur, input logic prev, input logic rising);
    edgeSeen = rising ? (cur && !prev) : (!cur && prev);
  endfunction : edgeSeen

  // ==========================================================
  // input synchronisers
  gppr_pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .asyncIn({xdIn, gpioIn}),
    .syncOut(syncLevel)
  );

  assign pinSync = syncLevel[GPPR_PINS-1:0];
  assign xdSync = syncLevel[SYNC_W-1:GPPR_PINS];

  // ==========================================================
  // apb slave
  // zero wait states; read data is latched in the setup cycle so it
  // comes from a flip-flop by the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit(paddr);
  assign wrStrobe = psel && penable && pwrite && addrHit(paddr);
  assign rdSetup = psel && !penable && !pwrite;
  assign prdata = prdata_reg;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata_reg <= '0;
    end else if (rdSetup) begin
      prdata_reg <= '0;
      case (paddr)
        GPPR_ADDR_CONTROL: begin
          prdata_reg[GPPR_REG_W-1:0] <= control_reg;
        end
        GPPR_ADDR_B0_OUT: begin
          prdata_reg[GPPR_REG_W-1:0] <= bank0Out_reg;
        end
        GPPR_ADDR_B1_OUT: begin
          prdata_reg[GPPR_REG_W-1:0] <= bank1Out_reg;
        end
        GPPR_ADDR_B0_IN: begin
          prdata_reg[GPPR_REG_W-1:0] <= pinSync[GPPR_REG_W-1:0];
        end
        GPPR_ADDR_B1_IN: begin
          prdata_reg[GPPR_REG_W-1:0] <= pinSync[GPPR_PINS-1:GPPR_REG_W];
        end
        GPPR_ADDR_B0_DIR: begin
          prdata_reg[GPPR_REG_W-1:0] <= bank0Dir_reg;
        end
        GPPR_ADDR_B1_DIR: begin
          prdata_reg[GPPR_REG_W-1:0] <= bank1Dir_reg;
        end
        default: begin
          prdata_reg <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // control register
  always_comb begin
    // reserved bits are dropped even if software sets them
    control_next = pwdata[GPPR_REG_W-1:0] & GPPR_CTL_WRITABLE;
    if (control_reg[GPPR_CTL_WP]) begin
      control_next = (control_next & ~GPPR_CTL_LOCKED) | (control_reg & GPPR_CTL_LOCKED);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      control_reg <= GPPR_RST_REG;
    end else if (wrStrobe && paddr == GPPR_ADDR_CONTROL) begin
      control_reg <= control_next;
    end
  end

  // ==========================================================
  // bank registers
  // cleared at reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bank0Out_reg <= GPPR_RST_REG;
      bank1Out_reg <= GPPR_RST_REG;
      bank0Dir_reg <= GPPR_RST_REG;
      bank1Dir_reg <= GPPR_RST_REG;
    end else if (wrStrobe) begin
      case (paddr)
        GPPR_ADDR_B0_OUT: begin
          bank0Out_reg <= pwdata[GPPR_REG_W-1:0];
        end
        GPPR_ADDR_B1_OUT: begin
          bank1Out_reg <= pwdata[GPPR_REG_W-1:0];
        end
        GPPR_ADDR_B0_DIR: begin
          bank0Dir_reg <= pwdata[GPPR_REG_W-1:0];
        end
        GPPR_ADDR_B1_DIR: begin
          bank1Dir_reg <= pwdata[GPPR_REG_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // route decode
  // mode field
  assign mode = gppr_mode_t'(control_reg[GPPR_CTL_MODE_HI:GPPR_CTL_MODE_LO]);
  assign pinMode = mode;
  assign fsOnXd = control_reg[GPPR_CTL_FS_XD];
  assign fsOnPins = control_reg[GPPR_CTL_FS_PIN] && !fsOnXd;
  assign spiOnXd = control_reg[GPPR_CTL_SPI_XD];
  assign spiOnPins = control_reg[GPPR_CTL_SPI_PIN] && !spiOnXd;
  assign altSsActive = control_reg[GPPR_CTL_ALT_SS] && spiOnPins;

  // ==========================================================
  // pin drive selection, lowest priority first
  always_comb begin
    pinOut_next = {bank1Out_reg, bank0Out_reg};
    pinOe_next = {bank1Dir_reg, bank0Dir_reg};
    if (control_reg[GPPR_CTL_UD]) begin
      pinOut_next[GPPR_PIN_UD] = txEnStatus;
      pinOe_next[GPPR_PIN_UD] = 1'b1;
    end
    if (spiOnPins) begin
      for (int i = 0; i < GPPR_LANES; i++) begin
        if (!(altSsActive && i == GPPR_SPI_SS_LANE)) begin
          pinOut_next[GPPR_PIN_SPI_LO + i] = spiOut[i];
          pinOe_next[GPPR_PIN_SPI_LO + i] = spiOe[i];
        end
      end
    end
    // moved select is an input only
    if (altSsActive) begin
      pinOut_next[GPPR_PIN_ALT_SS] = 1'b0;
      pinOe_next[GPPR_PIN_ALT_SS] = 1'b0;
    end
    if (fsOnPins) begin
      for (int i = 0; i < GPPR_LANES; i++) begin
        if (i == GPPR_FS_HI_LANE) begin
          pinOut_next[GPPR_PIN_FS_HI] = fastSerialOut[i];
          pinOe_next[GPPR_PIN_FS_HI] = fastSerialOe[i];
        end else begin
          pinOut_next[GPPR_PIN_FS_LO + i] = fastSerialOut[i];
          pinOe_next[GPPR_PIN_FS_LO + i] = fastSerialOe[i];
        end
      end
    end
    // mode peripherals take pins 15:0 and 24:19
    case (mode)
      GPPR_MODE_DRIVE: begin
        pinOut_next = (pinOut_next & ~GPPR_MODE_PIN_MASK) | (drivePortOut & GPPR_MODE_PIN_MASK);
        pinOe_next = (pinOe_next & ~GPPR_MODE_PIN_MASK) | (drivePortOe & GPPR_MODE_PIN_MASK);
      end
      GPPR_MODE_HOST: begin
        pinOut_next = (pinOut_next & ~GPPR_MODE_PIN_MASK) | (hostPortOut & GPPR_MODE_PIN_MASK);
        pinOe_next = (pinOe_next & ~GPPR_MODE_PIN_MASK) | (hostPortOe & GPPR_MODE_PIN_MASK);
      end
      default: begin
        // gpio, reserved and scan codes leave the pins to the registers;
        // scan is for production test and is not built here
      end
    endcase
  end

  // ==========================================================
  // memory data line drive selection
  always_comb begin
    xdOut_next = '0;
    xdOe_next = '0;
    xdClaim_next = '0;
    for (int i = 0; i < GPPR_LANES; i++) begin
      if (fsOnXd) begin
        xdOut_next[GPPR_XD_FS_LO - GPPR_XD_LO + i] = fastSerialOut[i];
        xdOe_next[GPPR_XD_FS_LO - GPPR_XD_LO + i] = fastSerialOe[i];
        xdClaim_next[GPPR_XD_FS_LO - GPPR_XD_LO + i] = 1'b1;
      end
      if (spiOnXd) begin
        xdOut_next[GPPR_XD_SPI_LO - GPPR_XD_LO + i] = spiOut[i];
        xdOe_next[GPPR_XD_SPI_LO - GPPR_XD_LO + i] = spiOe[i];
        xdClaim_next[GPPR_XD_SPI_LO - GPPR_XD_LO + i] = 1'b1;
      end
    end
  end

  // ==========================================================
  // peripheral receive paths
  always_comb begin
    fastSerialIn_next = '0;
    spiIn_next = '0;
    for (int i = 0; i < GPPR_LANES; i++) begin
      if (fsOnXd) begin
        fastSerialIn_next[i] = xdSync[GPPR_XD_FS_LO - GPPR_XD_LO + i];
      end else if (fsOnPins) begin
        fastSerialIn_next[i] = (i == GPPR_FS_HI_LANE) ? pinSync[GPPR_PIN_FS_HI] : pinSync[GPPR_PIN_FS_LO + i];
      end
      if (spiOnXd) begin
        spiIn_next[i] = xdSync[GPPR_XD_SPI_LO - GPPR_XD_LO + i];
      end else if (spiOnPins) begin
        spiIn_next[i] = pinSync[GPPR_PIN_SPI_LO + i];
      end
    end
    // select taken from the alternate pin
    if (altSsActive) begin
      spiIn_next[GPPR_SPI_SS_LANE] = pinSync[GPPR_PIN_ALT_SS];
    end
  end

  // ==========================================================
  // registered pin and peripheral outputs
  // one cycle of latency traded for glitch free pad drive
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pinOut_reg <= '0;
      pinOe_reg <= '0;
      xdOut_reg <= '0;
      xdOe_reg <= '0;
      xdClaim_reg <= '0;
      fastSerialIn_reg <= '0;
      spiIn_reg <= '0;
    end else begin
      pinOut_reg <= pinOut_next;
      pinOe_reg <= pinOe_next;
      xdOut_reg <= xdOut_next;
      xdOe_reg <= xdOe_next;
      xdClaim_reg <= xdClaim_next;
      fastSerialIn_reg <= fastSerialIn_next;
      spiIn_reg <= spiIn_next;
    end
  end

  assign gpioOut = pinOut_reg;
  assign gpioOe = pinOe_reg;
  assign pinLevel = pinSync;
  assign xdOut = xdOut_reg;
  assign xdOe = xdOe_reg;
  assign xdClaim = xdClaim_reg;
  assign fastSerialIn = fastSerialIn_reg;
  assign spiIn = spiIn_reg;

  // ==========================================================
  // pin interrupts
  // sense pins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irqAPrev_reg <= 1'b0;
      irqBPrev_reg <= 1'b0;
    end else begin
      irqAPrev_reg <= pinSync[GPPR_PIN_IRQA];
      irqBPrev_reg <= pinSync[GPPR_PIN_IRQB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pinIrqA_reg <= 1'b0;
      pinIrqB_reg <= 1'b0;
    end else begin
      pinIrqA_reg <= control_reg[GPPR_CTL_IRQA_EN] && cpuGpioIntEn &&
                     edgeSeen(pinSync[GPPR_PIN_IRQA], irqAPrev_reg, control_reg[GPPR_CTL_IRQA_POL]);
      pinIrqB_reg <= control_reg[GPPR_CTL_IRQB_EN] && cpuGpioIntEn &&
                     edgeSeen(pinSync[GPPR_PIN_IRQB], irqBPrev_reg, control_reg[GPPR_CTL_IRQB_POL]);
    end
  end

  assign pinIrqA = pinIrqA_reg;
  assign pinIrqB = pinIrqB_reg;

endmodule : gppr_top

// ==== tb/gppr_checker.sv ====
// gppr_checker: port-level assertions for gppr_top.
// assumes a bind onto gppr_top, one clock, synchronous low reset.
`timescale 1ns/10ps
module gppr_checker
  import gppr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [gppr_pkg::GPPR_DATA_W-1:0] pwdata,
  input wire logic pslverr,
  input wire logic [31:0] gpioOut,
  input wire logic [31:0] gpioOe,
  input wire logic [31:0] pinLevel,
  input wire gppr_pkg::gppr_mode_t pinMode,
  input wire logic cpuGpioIntEn,
  input wire logic pinIrqA,
  input wire logic pinIrqB
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic acc;
  assign acc = psel && penable && pwrite;
  // ==========================================
  // assertions
  a_reset_clear: assert property ($rose(reset_n) |-> gpioOe == '0 && gpioOut == '0)
    else $error("pins not cleared after reset");
  a_out_follow: assert property (acc && paddr == GPPR_ADDR_B0_OUT && pinMode == GPPR_MODE_GPIO
    |-> ##2 gpioOut[7:0] == $past(pwdata[7:0], 2)) else $error("bank0 output not on pins");
  a_dir_follow: assert property (acc && paddr == GPPR_ADDR_B0_DIR && pinMode == GPPR_MODE_GPIO
    |-> ##2 gpioOe[7:0] == $past(pwdata[7:0], 2)) else $error("bank0 direction not on pins");
  a_bank1_out: assert property (acc && paddr == GPPR_ADDR_B1_OUT
    |-> ##2 gpioOut[29:27] == $past(pwdata[13:11], 2)) else $error("bank1 output not on pins");
  a_irqa_gate: assert property (pinIrqA |-> $past(cpuGpioIntEn))
    else $error("first irq while cpu enable low");
  a_irqb_gate: assert property (pinIrqB |-> $past(cpuGpioIntEn))
    else $error("second irq while cpu enable low");
  a_irqa_pin: assert property (pinIrqA |-> pinLevel[24] != $past(pinLevel[24], 3))
    else $error("first irq without pin 24 edge");
  a_irqb_pin: assert property (pinIrqB |-> pinLevel[25] != $past(pinLevel[25], 3))
    else $error("second irq without pin 25 edge");
  a_mode_hold: assert property (!(acc && paddr == GPPR_ADDR_CONTROL) |=> $stable(pinMode))
    else $error("pin mode moved without write");
  c_irqa: cover property (pinIrqA);
  c_irqb: cover property (pinIrqB);
  c_err: cover property (pslverr);
  c_host: cover property (pinMode == GPPR_MODE_HOST);
endmodule : gppr_checker

// ==== tb/gppr_pin_world.sv ====
// gppr_pin_world: external circuitry on gpio pins and memory data lines.
// assumes the bench sets the level seen on every undriven line.
`timescale 1ns/10ps
module gppr_pin_world (
  input wire logic [31:0] gpioOut,
  input wire logic [31:0] gpioOe,
  input wire logic [31:0] extLevel,
  input wire logic [15:8] xdOut,
  input wire logic [15:8] xdOe,
  input wire logic [15:8] xdExt,
  output logic [31:0] gpioIn,
  output logic [15:8] xdIn
);
  // ==========================================
  // wire resolution
  // driven bit wins, else outside level
  assign gpioIn = (gpioOut & gpioOe) | (extLevel & ~gpioOe);
  assign xdIn = (xdOut & xdOe) | (xdExt & ~xdOe);
endmodule : gppr_pin_world

// ==== tb/tb_gppr_top.sv ====
// tb_gppr_top: self-checking bench for gppr_top over apb and pins.
// assumes gppr_pin_world on the pins and gppr_checker bound at the foot.
`timescale 1ns/10ps
module tb_gppr_top;
  import gppr_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cpuGpioIntEn = 1'b0, txEnStatus = 1'b0, pready, pslverr, pinIrqA, pinIrqB, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, extLevel = 32'h0, rd, prdata, gpioIn, gpioOut, gpioOe, pinLevel;
  logic [31:0] hostPortOut = 32'h5555_5555, drivePortOut = 32'hAAAA_AAAA, hostPortOe = 32'hFFFF_FFFF;
  logic [31:0] drivePortOe = 32'hFFFF_FFFF;
  logic [15:8] xdIn, xdOut, xdOe, xdClaim, xdExt = 8'h00;
  logic [3:0] fastSerialOut = 4'h0, fastSerialOe = 4'h0, fastSerialIn, spiOut = 4'h0, spiOe = 4'h0, spiIn;
  logic [31:0] regs [7] = '{GPPR_ADDR_CONTROL, GPPR_ADDR_B0_OUT, GPPR_ADDR_B0_IN, GPPR_ADDR_B0_DIR,
    GPPR_ADDR_B1_OUT, GPPR_ADDR_B1_IN, GPPR_ADDR_B1_DIR};
  gppr_mode_t pinMode;
  int numErrors = 0, totalChecks = 0, cyc = 0;
  gppr_top uut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpioIn, .gpioOut, .gpioOe, .pinLevel, .xdIn, .xdOut, .xdOe, .xdClaim, .fastSerialOut, .fastSerialOe,
    .fastSerialIn, .spiOut, .spiOe, .spiIn, .hostPortOut, .hostPortOe, .drivePortOut, .drivePortOe,
    .pinMode, .txEnStatus, .cpuGpioIntEn, .pinIrqA, .pinIrqB);
  gppr_pin_world pw (.gpioOut, .gpioOe, .extLevel, .xdOut, .xdOe, .xdExt, .gpioIn, .xdIn);
  initial forever #2 sys_clk = ~sys_clk;
  // ==========================================
  // shared tasks
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      numErrors++;
      conclude();
    end
  end
  task chk(input string n, input logic [31:0] e, s);
    totalChecks++;
    if (s !== e) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // wait on pready, no assumed latency
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk("register read", e, rd);
  endtask : rdc
  // covers sync chain plus pin pipeline
  task settle();
    repeat (8) @(negedge sys_clk);
  endtask : settle
  task ctl(input logic [31:0] v);
    apb(1'b1, GPPR_ADDR_CONTROL, v);
    settle();
  endtask : ctl
  task rst();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : rst
  task ie(input int p, input logic lv, en, input int ex);
    int hit, oth;
    hit = 0;
    oth = 0;
    @(posedge sys_clk);
    extLevel[p] <= lv;
    cpuGpioIntEn <= en;
    repeat (12) begin
      @(negedge sys_clk);
      hit += ((p == 24 ? pinIrqA : pinIrqB) === 1'b1);
      oth += ((p == 24 ? pinIrqB : pinIrqA) === 1'b1);
    end
    chk("irq pulses", ex, hit);
    chk("other irq", 0, oth);
  endtask : ie
  // ==========================================
  // scenarios
  task t_bank();
    foreach (regs[i]) rdc(regs[i], 32'h0);
    apb(1'b0, 32'h0003_0004, 32'h0);
    chk("unmapped err", 32'h1, er);
    @(posedge sys_clk);
    extLevel <= 32'h0F0F_F0F0;
    apb(1'b1, GPPR_ADDR_B0_OUT, 32'hA5C3);
    apb(1'b1, GPPR_ADDR_B0_DIR, 32'h00FF);
    apb(1'b1, GPPR_ADDR_B1_OUT, 32'h3C5A);
    apb(1'b1, GPPR_ADDR_B1_DIR, 32'hFCFF);
    settle();
    chk("gpioOut", 32'h3C5A_A5C3, gpioOut);
    chk("gpioOe", 32'hFCFF_00FF, gpioOe);
    chk("pinLevel", 32'h3F5A_F0C3, pinLevel);
    rdc(GPPR_ADDR_B0_OUT, 32'hA5C3);
    rdc(GPPR_ADDR_B0_IN, 32'hF0C3);
    rdc(GPPR_ADDR_B1_IN, 32'h3F5A);
    $display("t_bank done");
  endtask : t_bank
  task t_irq();
    ctl(32'h000F);
    ie(24, 1'b0, 1'b1, 0);
    ie(24, 1'b1, 1'b1, 1);
    ie(25, 1'b0, 1'b1, 0);
    ie(25, 1'b1, 1'b1, 1);
    ctl(32'h0005);
    ie(24, 1'b0, 1'b1, 1);
    ie(25, 1'b0, 1'b1, 1);
    ie(24, 1'b1, 1'b0, 0);
    ie(24, 1'b0, 1'b0, 0);
    ie(25, 1'b1, 1'b0, 0);
    ie(25, 1'b0, 1'b0, 0);
    ctl(32'h000A);
    ie(24, 1'b1, 1'b1, 0);
    ie(25, 1'b1, 1'b1, 0);
    $display("t_irq done");
  endtask : t_irq
  task t_route();
    @(posedge sys_clk);
    spiOut <= 4'hA;
    spiOe <= 4'hF;
    fastSerialOut <= 4'h5;
    fastSerialOe <= 4'hF;
    txEnStatus <= 1'b1;
    ctl(32'h0020);
    chk("spi pins", 32'hFA, {gpioOe[11:8], gpioOut[11:8]});
    chk("spi in", 32'hA, spiIn);
    ctl(32'h0820);
    chk("alt select", 32'h0DA, {gpioOe[15:8], spiIn});
    ctl(32'h0030);
    chk("spi xd", 32'hFA, {xdOe[11:8], xdOut[11:8]});
    chk("spi pins freed", 32'h0, gpioOe[11:8]);
    chk("spi claim", 32'h0F, xdClaim);
    ctl(32'h0080);
    chk("fs pins", 32'h5, {gpioOut[26], gpioOut[18:16]});
    chk("fs in", 32'h5, fastSerialIn);
    ctl(32'h00C0);
    chk("fs xd", 32'h5, xdOut[15:12]);
    chk("fs pins freed", 32'h7, gpioOe[18:16]);
    chk("fs xd in", 32'h5, fastSerialIn);
    chk("fs claim", 32'hF0, xdClaim);
    ctl(32'h4000);
    chk("tx en pin", 32'h3, {gpioOe[30], gpioOut[30]});
    ctl({GPPR_MODE_HOST, 8'h00});
    chk("host pins", hostPortOut & GPPR_MODE_PIN_MASK, gpioOut & GPPR_MODE_PIN_MASK);
    chk("host oe", GPPR_MODE_PIN_MASK, gpioOe & GPPR_MODE_PIN_MASK);
    ctl({GPPR_MODE_DRIVE, 8'h00});
    chk("drive pins", drivePortOut & GPPR_MODE_PIN_MASK, gpioOut & GPPR_MODE_PIN_MASK);
    ctl({GPPR_MODE_RSV1, 8'h00});
    chk("reserved pins", 32'h3C5A_A5C3 & GPPR_MODE_PIN_MASK, gpioOut & GPPR_MODE_PIN_MASK);
    ctl(32'h8500);
    ctl(32'h0000);
    chk("locked mode", GPPR_MODE_HOST, pinMode);
    rdc(GPPR_ADDR_CONTROL, 32'h8500);
    rst();
    rdc(GPPR_ADDR_CONTROL, 32'h0);
    rdc(GPPR_ADDR_B0_DIR, 32'h0);
    $display("t_route done");
  endtask : t_route
  task conclude();
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    rst();
    t_bank();
    t_irq();
    t_route();
    conclude();
  end
endmodule : tb_gppr_top
bind gppr_top gppr_checker chk_i (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .gpioOut, .gpioOe, .pinLevel, .pinMode, .cpuGpioIntEn, .pinIrqA, .pinIrqB);
